// ===== design/fci_defs.svh
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH
// matrix side and size in coded bits
`define FCI_DIM       4
`define FCI_MAT_BITS  16
// packet length selection value meaning fixed length
`define FCI_LEN_FIXED 2'h0
// second generator taps on the shift register (1 + D + D^3)
`define FCI_G1_TAPS   3'h5
`define FCI_SR_RESET  3'h0
`define FCI_LEN_W     8
// last coded write slot of a byte, last read slot of a matrix
`define FCI_WR_LAST   4'he
`define FCI_RD_LAST   4'hf
`define FCI_PAIR_LAST 3'h7
`endif

// ===== design/fci_pkg.sv
`include "fci_defs.svh"
package fci_pkg;

  typedef enum logic [1:0] {
    FCI_TX_IDLE,
    FCI_TX_FILL,
    FCI_TX_DRAIN
  } fci_tx_st_t;

  typedef enum logic {
    FCI_RX_IDLE,
    FCI_RX_RUN
  } fci_rx_st_t;

  typedef struct packed {
    fci_tx_st_t                    tx_st;
    logic                          tx_coded;
    logic [2:0]                    enc_sr;
    logic [`FCI_MAT_BITS-1:0]      tx_mat;
    logic [3:0]                    tx_wr;
    logic [3:0]                    tx_rd;
    logic                          tx_par;
    logic                          tx_ended;
    logic [1:0]                    tx_pad;
    logic                          tx_ready;
    logic                          air_bit;
    logic                          air_valid;
    logic                          air_last;
    fci_rx_st_t                    rx_st;
    logic                          rx_coded;
    logic [`FCI_MAT_BITS-1:0]      rx_mat;
    logic [`FCI_MAT_BITS-1:0]      rx_shadow;
    logic [3:0]                    rx_wr;
    logic [2:0]                    rx_pair;
    logic                          rx_drain;
    logic [`FCI_LEN_W-1:0]         rx_data_left;
    logic [`FCI_LEN_W:0]           rx_tot_left;
    logic                          rx_bit;
    logic                          rx_valid;
    logic                          rx_done;
  } fci_state_t;

endpackage

// ===== design/fci_codec.sv
// Behaviour
// RULE_01 - coding only with fixed length packets
// RULE_02 - code and decode payload plus CRC
// RULE_03 - rate half, constraint four encoder
// RULE_04 - interleaving always accompanies coding
// RULE_05 - separate four by four matrices
// RULE_06 - transmit: write rows, read columns
// RULE_07 - receive: write columns, read rows
// RULE_08 - append at least one termination byte
// RULE_09 - pad to even byte count
// RULE_10 - receive strips termination and padding bytes
// RULE_11 - host keeps payload at least two bytes
// RULE_12 - host never combines Manchester with coding
// RULE_13 - one polynomial pair, encoder reset per packet
// RULE_14 - bit stream with valid, bypass when off
`timescale 1ns/10ps
`include "fci_defs.svh"
module fci_codec #(
  parameter int MATRIX_DIM = `FCI_DIM
) (
  input  wire logic                  clock_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  ce_in,
  input  wire logic                  coding_enable_bit_in,
  input  wire logic [1:0]            length_config_in,
  input  wire logic                  tx_start_in,
  input  wire logic                  tx_bit_in,
  input  wire logic                  tx_valid_in,
  input  wire logic                  tx_last_in,
  output logic                       tx_ready_out,
  input  wire logic                  air_req_in,
  output logic                       air_bit_out,
  output logic                       air_valid_out,
  output logic                       air_last_out,
  input  wire logic                  rx_start_in,
  input  wire logic                  rx_end_in,
  input  wire logic [`FCI_LEN_W-1:0] rx_len_in,
  input  wire logic                  rx_air_bit_in,
  input  wire logic                  rx_air_valid_in,
  output logic                       rx_bit_out,
  output logic                       rx_valid_out,
  output logic                       rx_done_out
);

  // index arithmetic below is hard-wired to a 4x4 matrix
  if (MATRIX_DIM != `FCI_DIM) begin : g_dim_check
    $error("fci_codec: only a 4x4 interleaver matrix is supported");
  end

  fci_pkg::fci_state_t s;
  fci_pkg::fci_state_t n;

  logic       coding_ok;
  logic       enc_in;
  logic       enc_take;
  logic       tx_byte_end;
  logic       tx_last_now;
  logic [3:0] rx_slot;
  logic [3:0] tx_slot;

  // RULE_01 fixed length gate
  assign coding_ok = coding_enable_bit_in &&
                     (length_config_in == `FCI_LEN_FIXED);

  always_comb
  begin
    n           = s;
    n.air_valid = 1'b0;
    n.air_last  = 1'b0;
    n.rx_valid  = 1'b0;
    n.rx_done   = 1'b0;
    enc_in      = 1'b0;
    enc_take    = 1'b0;
    tx_byte_end = 1'b0;
    tx_last_now = 1'b0;
    // RULE_06 column-wise read order
    tx_slot     = {s.tx_rd[1:0], s.tx_rd[3:2]};
    // RULE_07 column-wise write order
    rx_slot     = {s.rx_wr[1:0], s.rx_wr[3:2]};

    unique case (s.tx_st)
      fci_pkg::FCI_TX_IDLE:
      begin
        if (tx_start_in)
        begin
          // RULE_04 interleaver follows coding
          n.tx_coded = coding_ok;
          // RULE_13 encoder cleared per packet
          n.enc_sr   = `FCI_SR_RESET;
          n.tx_wr    = 4'h0;
          n.tx_par   = 1'b0;
          n.tx_ended = 1'b0;
          n.tx_pad   = 2'h0;
          n.tx_ready = 1'b1;
          n.tx_st    = fci_pkg::FCI_TX_FILL;
        end
      end
      fci_pkg::FCI_TX_FILL:
      begin
        if (!s.tx_coded)
        begin
          // RULE_14 registered bypass path
          n.air_valid = tx_valid_in;
          n.air_bit   = tx_bit_in;
          n.air_last  = tx_valid_in && tx_last_in;
          if (tx_valid_in && tx_last_in)
          begin
            n.tx_ready = 1'b0;
            n.tx_st    = fci_pkg::FCI_TX_IDLE;
          end
        end
        else
        begin
          // padding bits are zeros, which also flush the trellis
          if (s.tx_pad != 2'h0)
          begin
            enc_take = 1'b1;
            enc_in   = 1'b0;
          end
          else if (tx_valid_in && s.tx_ready)
          begin
            enc_take    = 1'b1;
            enc_in      = tx_bit_in;
            tx_last_now = tx_last_in;
          end
          if (enc_take)
          begin
            // RULE_03 two coded bits per data bit
            n.tx_mat[s.tx_wr]      = enc_in;
            n.tx_mat[s.tx_wr + 4'h1] =
              enc_in ^ (^(s.enc_sr & `FCI_G1_TAPS));
            n.enc_sr = {s.enc_sr[1:0], enc_in};
            n.tx_wr  = s.tx_wr + 4'h2;
            tx_byte_end = (s.tx_wr == `FCI_WR_LAST);
          end
          if (tx_byte_end)
          begin
            n.tx_par   = ~s.tx_par;
            n.tx_ready = 1'b0;
            n.tx_rd    = 4'h0;
            n.tx_st    = fci_pkg::FCI_TX_DRAIN;
            if (s.tx_pad != 2'h0)
            begin
              n.tx_pad = s.tx_pad - 2'h1;
            end
            // RULE_08 at least one termination byte
            // RULE_09 one or two bytes to even
            if (tx_last_now)
            begin
              n.tx_ended = 1'b1;
              n.tx_pad   = n.tx_par ? 2'h1 : 2'h2;
            end
          end
        end
      end
      fci_pkg::FCI_TX_DRAIN:
      begin
        if (air_req_in)
        begin
          n.air_valid = 1'b1;
          n.air_bit   = s.tx_mat[tx_slot];
          n.tx_rd     = s.tx_rd + 4'h1;
          if (s.tx_rd == `FCI_RD_LAST)
          begin
            n.tx_wr = 4'h0;
            if (s.tx_ended && (s.tx_pad == 2'h0))
            begin
              n.air_last = 1'b1;
              n.tx_st    = fci_pkg::FCI_TX_IDLE;
            end
            else
            begin
              n.tx_ready = !s.tx_ended;
              n.tx_st    = fci_pkg::FCI_TX_FILL;
            end
          end
        end
      end
      default:
      begin
        n.tx_st = fci_pkg::FCI_TX_IDLE;
      end
    endcase

    unique case (s.rx_st)
      fci_pkg::FCI_RX_IDLE:
      begin
        if (rx_start_in)
        begin
          // RULE_04 de-interleaver follows coding
          n.rx_coded     = coding_ok;
          n.rx_wr        = 4'h0;
          n.rx_drain     = 1'b0;
          n.rx_data_left = rx_len_in;
          // RULE_10 total includes hidden bytes
          n.rx_tot_left  = {1'b0, rx_len_in} +
                           (rx_len_in[0] ? 9'h001 : 9'h002);
          n.rx_st        = fci_pkg::FCI_RX_RUN;
        end
      end
      fci_pkg::FCI_RX_RUN:
      begin
        if (!s.rx_coded)
        begin
          // RULE_14 registered bypass path
          n.rx_valid = rx_air_valid_in;
          n.rx_bit   = rx_air_bit_in;
        end
        else
        begin
          if (rx_air_valid_in)
          begin
            // RULE_05 receive matrix kept apart
            n.rx_mat[rx_slot] = rx_air_bit_in;
            n.rx_wr           = s.rx_wr + 4'h1;
            // shadow copy lets the next matrix fill while draining
            if (s.rx_wr == `FCI_RD_LAST)
            begin
              n.rx_shadow = n.rx_mat;
              n.rx_drain  = 1'b1;
              n.rx_pair   = 3'h0;
            end
          end
          if (s.rx_drain)
          begin
            // RULE_07 row-wise read to decoder
            // RULE_02 decode payload and CRC
            // RULE_13 systematic half of the pair
            n.rx_bit = s.rx_shadow[{s.rx_pair, 1'b0}];
            // RULE_10 hidden bytes never output
            n.rx_valid = (s.rx_data_left != '0);
            n.rx_pair  = s.rx_pair + 3'h1;
            if (s.rx_pair == `FCI_PAIR_LAST)
            begin
              n.rx_drain    = (s.rx_wr == `FCI_RD_LAST) &&
                              rx_air_valid_in;
              n.rx_tot_left = s.rx_tot_left - 9'h001;
              if (s.rx_data_left != '0)
              begin
                n.rx_data_left = s.rx_data_left - 8'h01;
              end
              if (s.rx_tot_left == 9'h001)
              begin
                n.rx_done = 1'b1;
                n.rx_st   = fci_pkg::FCI_RX_IDLE;
              end
            end
          end
        end
        // packet handler may abort at any time
        if (rx_end_in)
        begin
          n.rx_drain = 1'b0;
          n.rx_st    = fci_pkg::FCI_RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      s       <= '0;
      s.tx_st <= fci_pkg::FCI_TX_IDLE;
      s.rx_st <= fci_pkg::FCI_RX_IDLE;
    end
    else if (ce_in)
    begin
      s <= n;
    end
  end

  assign tx_ready_out  = s.tx_ready;
  assign air_bit_out   = s.air_bit;
  assign air_valid_out = s.air_valid;
  assign air_last_out  = s.air_last;
  assign rx_bit_out    = s.rx_bit;
  assign rx_valid_out  = s.rx_valid;
  assign rx_done_out   = s.rx_done;

endmodule // fci_codec

// ===== bench/fci_codec_props.sv
`timescale 1ns/10ps
module fci_codec_props (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic coding_enable_bit_in,
  input wire logic tx_bit_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  input wire logic tx_ready_out,
  input wire logic air_req_in,
  input wire logic air_bit_out,
  input wire logic air_valid_out,
  input wire logic air_last_out,
  input wire logic rx_air_bit_in,
  input wire logic rx_air_valid_in,
  input wire logic rx_bit_out,
  input wire logic rx_valid_out,
  input wire logic rx_done_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_pass;
    !coding_enable_bit_in && tx_valid_in && tx_ready_out;
  endsequence
  sequence s_burst;
    rx_valid_out [*8] ##1 !rx_valid_out;
  endsequence
  property p_pass;
    s_pass |=> air_valid_out && air_bit_out == $past(tx_bit_in);
  endproperty
  a_pass: assert property (p_pass) else $error("bypass bit lost");
  property p_pass_last;
    s_pass ##0 tx_last_in |=> air_last_out;
  endproperty
  a_pass_last: assert property (p_pass_last) else $error("no last");
  property p_last_stop;
    tx_valid_in && tx_ready_out && tx_last_in |=> !tx_ready_out;
  endproperty
  a_last_stop: assert property (p_last_stop) else $error("ready");
  property p_req;
    coding_enable_bit_in && air_valid_out |-> $past(air_req_in);
  endproperty
  a_req: assert property (p_req) else $error("unasked bit");
  property p_air_last;
    air_last_out |-> air_valid_out;
  endproperty
  a_air_last: assert property (p_air_last) else $error("bare last");
  property p_burst;
    coding_enable_bit_in && $rose(rx_valid_out) |-> s_burst;
  endproperty
  a_burst: assert property (p_burst) else $error("row burst");
  property p_rx_cause;
    coding_enable_bit_in && $rose(rx_valid_out)
      |-> $past(rx_air_valid_in, 2);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("early row");
  property p_done;
    rx_done_out |-> !rx_valid_out ##1 !rx_done_out;
  endproperty
  a_done: assert property (p_done) else $error("pad shown");
  property p_rx_pass;
    !coding_enable_bit_in && rx_valid_out
      |-> $past(rx_air_valid_in) && rx_bit_out == $past(rx_air_bit_in);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx copy");
endmodule // fci_codec_props
bind fci_codec fci_codec_props u_props (.*);

// ===== bench/fci_modem.sv
`timescale 1ns/10ps
module fci_modem (
  input  wire logic clock_in,
  input  wire logic slow_in,
  input  wire logic air_bit_in,
  input  wire logic air_valid_in,
  output logic      air_req_out,
  output logic      sym_bit_out,
  output logic      sym_valid_out
);
  logic [2:0] gap = 3'h0;
  initial {air_req_out, sym_bit_out, sym_valid_out} = 3'h0;
  // one request per two or eight cycles
  always @(posedge clock_in)
  begin
    gap <= gap + 3'h1;
    air_req_out <= slow_in ? (gap == 3'h0) : gap[0];
    sym_valid_out <= air_valid_in;
    // no line coding; idle line flips
    sym_bit_out <= air_valid_in ? air_bit_in : ~sym_bit_out;
  end
endmodule // fci_modem

// ===== bench/tb_fci_codec.sv
`timescale 1ns/10ps
module tb_fci_codec;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cod = 1'b0;
  logic [1:0] len_cfg = 2'h0;
  logic       tx_start = 1'b0;
  logic       tx_bit = 1'b0;
  logic       tx_valid = 1'b0;
  logic       tx_last = 1'b0;
  logic       rx_start = 1'b0;
  logic       rx_end = 1'b0;
  logic [7:0] rx_len = 8'h00;
  logic       slow = 1'b0;
  logic       tx_ready, air_req, air_bit, air_valid, air_last;
  logic       sym_bit, sym_valid, rx_bit, rx_valid, rx_done;
  logic       aq[$];
  logic       rq[$];
  int         failures = 0;
  int         comparisons = 0;
  fci_codec dut (.clock_in(clk), .sys_rst_in(rst), .ce_in(1'b1),
    .coding_enable_bit_in(cod), .length_config_in(len_cfg),
    .tx_start_in(tx_start), .tx_bit_in(tx_bit), .tx_valid_in(tx_valid),
    .tx_last_in(tx_last), .tx_ready_out(tx_ready), .air_req_in(air_req),
    .air_bit_out(air_bit), .air_valid_out(air_valid),
    .air_last_out(air_last), .rx_start_in(rx_start), .rx_end_in(rx_end),
    .rx_len_in(rx_len), .rx_air_bit_in(sym_bit),
    .rx_air_valid_in(sym_valid), .rx_bit_out(rx_bit),
    .rx_valid_out(rx_valid), .rx_done_out(rx_done));
  fci_modem peer (.clock_in(clk), .slow_in(slow), .air_bit_in(air_bit),
    .air_valid_in(air_valid), .air_req_out(air_req),
    .sym_bit_out(sym_bit), .sym_valid_out(sym_valid));
  initial forever #20 clk = ~clk;
  task automatic fail(input logic [7:0] e, input logic [7:0] g);
    failures++;
    $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic check(ref logic q[$], input logic g);
    logic e;
    e = q.size() ? q.pop_front() : 1'bx;
    comparisons++;
    if (g !== e) fail({7'h0, e}, {7'h0, g});
  endtask
  task automatic check_flag(input logic e, input logic g);
    comparisons++;
    if (g !== e) fail({7'h0, e}, {7'h0, g});
  endtask
  task automatic check_left(input int n);
    comparisons++;
    if (n != 0) fail(8'h00, n[7:0]);
  endtask
  task automatic summarize;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait, edge at which ready or done is seen high
  task automatic await(input logic want_done);
    int t;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while ((want_done ? rx_done : tx_ready) !== 1'b1 && t < 3000);
    if ((want_done ? rx_done : tx_ready) !== 1'b1)
    begin
      failures++;
      summarize;
    end
  endtask
  // rows written, columns sent
  task automatic code8(input logic [7:0] d, inout logic [2:0] s);
    logic [15:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m[2*i] = d[7-i];
      m[2*i+1] = d[7-i] ^ s[0] ^ s[2];
      s = {s[1:0], d[7-i]};
    end
    for (int i = 0; i < 16; i++) aq.push_back(m[(i%4)*4+i/4]);
  endtask
  task automatic run(input logic c, input int n);
    logic [7:0] d;
    logic [2:0] s;
    s = 3'h0;
    cod = c;
    // length selection free only when uncoded
    len_cfg = c ? 2'h0 : 2'($urandom);
    slow = 1'($urandom);
    rx_len = n[7:0];
    tx_start = 1'b1;
    rx_start = 1'b1;
    @(posedge clk);
    #1;
    tx_start = 1'b0;
    rx_start = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      d = 8'($urandom);
      if (c) code8(d, s);
      for (int b = 7; b >= 0; b--)
      begin
        rq.push_back(d[b]);
        if (!c) aq.push_back(d[b]);
        tx_bit = d[b];
        tx_last = (k == n - 1 && b == 0);
        tx_valid = 1'b1;
        await(1'b0);
        #1;
      end
    end
    tx_valid = 1'b0;
    // one pad if odd, two if even
    if (c) for (int k = 0; k < 2 - n % 2; k++) code8(8'h00, s);
    if (c) await(1'b1);
    else
    begin
      repeat (4) @(posedge clk);
      #1 rx_end = 1'b1;
      @(posedge clk);
      #1 rx_end = 1'b0;
    end
    @(posedge clk);
    #1;
    check_left(aq.size() + rq.size());
  endtask
  always @(posedge clk)
  begin
    if (air_valid === 1'b1) check_flag(aq.size() == 1, air_last);
    if (air_valid === 1'b1) check(aq, air_bit);
    if (rx_valid === 1'b1) check(rq, rx_bit);
  end
  initial
  begin
    void'($urandom(32'hf8ce));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    // payloads of two to four bytes, both modes
    for (int m = 0; m < 6; m++) run(m[0], 2 + m / 2);
    summarize;
  end
endmodule // tb_fci_codec
